/* File: bench/rcts_sensor_model.sv */
// Behavioural sensor, reference resistor and capacitor network behind the trigger paths.
`timescale 1ns/1ps
module rcts_sensor_model (
  input wire logic aclk,
  input wire logic cap_charge,
  input wire logic [3:0] port_on,
  input wire logic path_int,
  input wire logic [3:0][15:0] delay,
  output logic sense_ext,
  output logic sense_int
);
  logic [15:0] cnt = 16'h0000;
  logic tripped = 1'b0;
  logic [1:0] idx;
  assign idx = port_on[3] ? 2'h3 : port_on[2] ? 2'h2 : port_on[1] ? 2'h1 : 2'h0;
  always @(posedge aclk)
  begin
    if (port_on == 4'h0 || cap_charge)
    begin
      cnt <= 16'h0000;
      tripped <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 16'h0001;
      if (cnt + 16'h0001 >= delay[idx])
        tripped <= 1'b1;
    end
  end
  // selected trigger path.
  // The unused path flags a stop at once, so listening to it reads as a short.
  assign sense_ext = path_int ? (port_on != 4'h0) : tripped;
  assign sense_int = path_int ? !tripped : (port_on == 4'h0);
endmodule : rcts_sensor_model

/* File: bench/rcts_top_tb.sv */
// Self-checking bench for the discharge-time temperature sequencer.
`timescale 1ns/1ps
module rcts_top_tb;
  import rcts_pkg::*;
  localparam int CYC_L = 1000;
  localparam int LIMIT = 95000;
  localparam int TIMO_S = 200;
  localparam int TIMO_L = 300;
  localparam int QTR_50 = 50;
  localparam int QTR_60 = 40;
  localparam logic [11:0] CT [8] = '{12'h200, 12'hB8F, 12'h902, 12'h8FE, 12'hC06, 12'hD8A,
    12'hED2, 12'hF22};
  localparam int TWICE [8] = '{0, 0, 1, 1, 0, 0, 1, 1};
  localparam int SH [8] = '{4, 4, 4, 4, 1, 4, 0, 4};
  localparam int OPN [8] = '{4, 4, 4, 4, 2, 3, 4, 4};
  localparam int STL [8] = '{0, 0, 10, 20, 30, 40, 40, 40};
  typedef struct packed {
    logic [31:0] data;
    logic [7:0] tol;
    logic [1:0] resp;
  } rcts_note_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  rcts_axi_req_s req = '0;
  rcts_axi_rsp_s rsp;
  logic sense_ext, sense_int, cap_charge, pa, pb, pc, pd, fast_osc_en, irq, irq_n;
  logic path_int = 1'b0;
  logic [3:0][15:0] delay = '0;
  rcts_note_s notes[$];
  rcts_note_s n_cur;
  int rises[$];
  int obs[$];
  int fail_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int osc_t = 0;
  int seed = 20871;
  logic osc_first = 1'b0;
  logic cap_d = 1'b0;
  logic osc_d = 1'b0;
  logic [3:0] ports_d = 4'h0;

  rcts_top #(.CYC_LONG_P(CYC_L), .TIMO_SHORT_P(TIMO_S), .TIMO_LONG_P(TIMO_L), .QTR50_P(QTR_50),
    .QTR60_P(QTR_60), .SETTLE0_P(STL[2]), .SETTLE1_P(STL[3]), .SETTLE2_P(STL[4]),
    .SETTLE3_P(STL[5])) dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .sense_ext(sense_ext),
    .sense_int(sense_int), .cap_charge(cap_charge), .sense_port_a(pa), .sense_port_b(pb),
    .sense_port_c(pc), .sense_port_d(pd), .fast_osc_en(fast_osc_en), .irq(irq),
    .irq_n(irq_n));
  rcts_sensor_model partner (.aclk(aclk), .cap_charge(cap_charge),
    .port_on({pd, pc, pb, pa}), .path_int(path_int), .delay(delay),
    .sense_ext(sense_ext), .sense_int(sense_int));

  initial
  begin
    forever #25 aclk = ~aclk;
  end

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input int tol,
    input string what);
    n_compared++;
    if ((got >= exp && got <= exp + tol) !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_val

  // Bus answers are paired with the oldest note; only one transfer is ever outstanding.
  always @(posedge aclk)
  begin
    if ((req.bready && rsp.bvalid) || (req.rready && rsp.rvalid))
    begin
      n_cur = notes.pop_front();
      if (req.rready && rsp.rvalid)
        cmp_val(rsp.rdata, n_cur.data, n_cur.tol, "read data");
      cmp_val({30'h0, req.rready ? rsp.rresp : rsp.bresp}, {30'h0, n_cur.resp}, 0,
        "resp");
    end
  end

  always @(posedge aclk)
  begin
    cyc_n <= cyc_n + 1;
    cap_d <= cap_charge;
    osc_d <= fast_osc_en;
    ports_d <= {pd, pc, pb, pa};
    if (cap_charge && !cap_d && rises.size() == 0)
      osc_first <= fast_osc_en;
    if (cap_charge && !cap_d)
      rises.push_back(cyc_n);
    if ({pd, pc, pb, pa} != 4'h0 && ports_d == 4'h0)
      obs.push_back(pb ? 1 : pc ? 2 : pd ? 3 : 0);
    if (fast_osc_en && !osc_d)
      osc_t <= cyc_n;
    if (cyc_n == LIMIT)
    begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      conclude();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic done = 1'b0;
    @(posedge aclk);
    notes.push_back('{32'h0, 8'h0, resp});
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid)
        req.bready <= 1'b0;
      done = req.bready && rsp.bvalid;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input int tol,
    input logic [1:0] resp);
    logic done = 1'b0;
    @(posedge aclk);
    notes.push_back('{d, tol[7:0], resp});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid)
        req.rready <= 1'b0;
      done = req.rready && rsp.rvalid;
    end
  endtask : rd

  task automatic run(input int s);
    logic [11:0] c = CT[s];
    int dum = c[0] ? 7 : 2;
    int np = c[2] ? 4 : 2;
    int cyc = c[1] ? CYC_L : CYC_SHORT;
    int g = c[10:8];
    int k = 0;
    int p = 0;
    logic [31:0] st = 32'h1;
    logic [31:0] e;
    logic ms, sh, op;
    rises.delete();
    obs.delete();
    path_int <= c[7];
    for (int i = 0; i < 4; i++)
      delay[i] <= (i == SH[s]) ? 16'h000A : (i == OPN[s]) ? 16'hFFFF
        : 16'(50 + ($random(seed) & 63));
    wr(OFF_MASK, {31'h0, s != 0}, RESP_OKAY);
    wr(OFF_CTRL, {20'h0, c}, RESP_OKAY);
    wr(OFF_CMD, {28'h0, TWICE[s] ? OP_TEMP_TWICE : OP_TEMP}, RESP_OKAY);
    cmp_val(irq_n, 1, 0, "irq_n after opcode");
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    while (irq_n !== 1'b0)
      @(posedge aclk);
    repeat (3) @(posedge aclk);
    k = (1 + TWICE[s]) * (dum + np);
    cmp_val(obs.size(), k, 0, "discharge count");
    for (int i = 0; i < obs.size() && i < k; i++)
    begin
      p = i % (dum + np) - dum;
      p = p < 0 ? (c[3] ? 3 : 0) : (c[3] ? 3 - p : p);
      cmp_val(obs[i], p, 0, "port order");
    end
    cmp_val(rises[1] - rises[0], cyc - 2, 4, "cycle length");
    if (TWICE[s])
      cmp_val(rises[k / 2] - rises[k / 2 - 1], cyc + (c[4] ? QTR_60 : QTR_50) * (c[6:5] + 2) - 2,
        g > 1 ? 48 : 8, "mains gap");
    if (g > 1)
      cmp_val(rises[0] - osc_t, STL[g] - 1, 6, "settle delay");
    cmp_val(osc_first, g != 0, 0, "osc during run");
    cmp_val(fast_osc_en, g == 1, 0, "osc after run");
    rd(OFF_CTRL, {20'h0, c}, 0, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      ms = c[3] ? i >= 4 - np : i < np;
      sh = delay[i] == 16'h000A;
      op = delay[i] == 16'hFFFF;
      st[11] = st[11] | (ms & sh);
      st[12] = st[12] | (ms & op);
      e = sh ? RES_SHORT : op ? RES_OPEN : {16'h0000, delay[i]} - 32'h2;
      if (ms)
        rd(OFF_RES0 + 8'(4 * i), e, (sh | op) ? 0 : 8, RESP_OKAY);
    end
    rd(OFF_STATUS, st, 0, RESP_OKAY);
    cmp_val(irq, s != 0, 0, "irq level");
    wr(OFF_STATUS, 32'h00001801, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, 0, RESP_OKAY);
    cmp_val(irq, 0, 0, "irq cleared");
    cmp_val(irq_n, 0, 0, "irq_n held");
  endtask : run

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL, 32'h0, 0, RESP_OKAY);
    rd(OFF_MASK, RESET_MASK, 0, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, 0, RESP_OKAY);
    rd(OFF_STATE, 32'h0, 0, RESP_OKAY);
    rd(8'h40, 32'h0, 0, RESP_SLVERR);
    wr(8'h44, 32'hFFFFFFFF, RESP_SLVERR);
    for (int s = 0; s < 8; s++)
      run(s);
    rd(OFF_CMD, 32'h0, 0, RESP_OKAY);
    conclude();
  end
endmodule : rcts_top_tb

/* File: inc/rcts_pkg.sv */
// Constants, types and register map of the discharge-time temperature sequencer.
package rcts_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_RES0 = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h20;
  // Control field positions.
  localparam int CB_DUMMY = 0;
  localparam int CB_CYCLE = 1;
  localparam int CB_PORTS = 2;
  localparam int CB_ORDER = 3;
  localparam int CB_MAINS = 4;
  localparam int CB_FACTOR = 5;
  localparam int CB_TRIG = 7;
  localparam int CB_OSC = 8;
  localparam int CB_TIMO = 11;
  localparam int CTRL_W = 12;
  // Status bit positions.
  localparam int SB_DONE = 0;
  localparam int SB_SHORT = 11;
  localparam int SB_OPEN = 12;
  localparam logic [31:0] RESET_MASK = 32'h00000000;
  localparam logic [3:0] OP_TEMP = 4'h1;
  localparam logic [3:0] OP_TEMP_TWICE = 4'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RES_SHORT = 32'h00000000;
  localparam logic [31:0] RES_OPEN = 32'h0FFFFFFF;
  // Timing in printed units and derived cycle counts.
  localparam int CYCLE_SHORT_US = 128;
  localparam int CYCLE_LONG_US = 512;
  localparam int CYC_SHORT = CYCLE_SHORT_US * CLK_MHZ;
  localparam int CYC_LONG = CYCLE_LONG_US * CLK_MHZ;
  localparam int TREF_NS = 250;
  localparam int SHORT_REFS = 8;
  localparam int SHORT_CYC = (SHORT_REFS * TREF_NS * CLK_MHZ + 999) / 1000;
  localparam int CHARGE_US = 16;
  localparam int CHARGE_CYC = CHARGE_US * CLK_MHZ;
  localparam int TIMO_SHORT_US = 256;
  localparam int TIMO_LONG_US = 2000;
  localparam int TIMO_SHORT_CYC = TIMO_SHORT_US * CLK_MHZ;
  localparam int TIMO_LONG_CYC = TIMO_LONG_US * CLK_MHZ;
  localparam int MAINS50_HZ = 50;
  localparam int MAINS60_HZ = 60;
  localparam int QTR50_CYC = CLK_MHZ * 1000000 / (4 * MAINS50_HZ);
  localparam int QTR60_CYC = CLK_MHZ * 1000000 / (4 * MAINS60_HZ);
  localparam int SETTLE0_US = 480;
  localparam int SETTLE1_US = 1460;
  localparam int SETTLE2_US = 2440;
  localparam int SETTLE3_US = 5140;
  localparam int SETTLE0_CYC = SETTLE0_US * CLK_MHZ;
  localparam int SETTLE1_CYC = SETTLE1_US * CLK_MHZ;
  localparam int SETTLE2_CYC = SETTLE2_US * CLK_MHZ;
  localparam int SETTLE3_CYC = SETTLE3_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETTLE = 3'h1,
    ST_CHARGE = 3'h2,
    ST_DISCH = 3'h3,
    ST_REST = 3'h4,
    ST_MAINS = 3'h5
  } rcts_seq_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rcts_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcts_axi_rsp_s;

  typedef struct packed {
    rcts_axi_rsp_s rsp;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] status;
    logic [31:0] mask;
    logic [3:0][31:0] res;
    rcts_seq_e state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cyc;
    logic [3:0] step;
    logic rep2;
    logic [3:0] port_en;
    logic charge;
    logic osc_en;
    logic irq;
    logic irq_n;
    logic [1:0] sync_ext;
    logic [1:0] sync_int;
  } rcts_state_s;

  localparam rcts_state_s STATE_RST = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    irq_n: 1'b1,
    state: ST_IDLE,
    mask: RESET_MASK,
    default: '0
  };
endpackage : rcts_pkg

/* File: rtl/rcts_top.sv */
// Discharge-time temperature sequencer with an AXI4-Lite register slave.
// Operation
// RULE1: Reading equals capacitor discharge time until the trigger threshold is crossed.
// RULE2: Start opcode runs dummies, then every enabled port, then flags completion.
// RULE3: Dummy count field selects two or seven dummy discharges.
// RULE4: Cycle time field selects 128 us or 512 us per measurement.
// RULE5: Port count field enables two ports or four ports.
// RULE6: Order bit reverses port order; reversed dummies use the fourth port.
// RULE7: Repeat opcode runs the whole measurement twice with a mains-based gap.
// RULE8: Mains bit picks a 50 Hz or 60 Hz period for that gap.
// RULE9: Delay factor codes 0 to 3 scale the period by 0.5 to 1.25.
// RULE10: Trigger path bit picks the external or internal Schmitt trigger.
// RULE11: Port results land in result registers 0 to 3.
// RULE12: Short or open sets status bit 11 or 12 and an error code.
// RULE13: Discharge shorter than eight reference periods is short; result is zero.
// RULE14: Missing stop or timeout is open; result is the all-ones code (RES_OPEN here is 0x0FFFFFFF, top four bits zero).
// RULE15: Host sets the 2 ms timeout when the long cycle is used.
// RULE16: Host should pick the long cycle to avoid overflow at 150 us.
// RULE17: Oscillator field: off, always on, or gated with a settling delay.
// RULE18: Gated oscillator turns on at a start opcode, off when it ends.
// RULE19: Interrupt output stays low after completion until a new opcode or reset.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rcts_top
  import rcts_pkg::*;
#(
  parameter int unsigned CYC_LONG_P = CYC_LONG,
  parameter int unsigned TIMO_SHORT_P = TIMO_SHORT_CYC,
  parameter int unsigned TIMO_LONG_P = TIMO_LONG_CYC,
  parameter int unsigned QTR50_P = QTR50_CYC,
  parameter int unsigned QTR60_P = QTR60_CYC,
  parameter int unsigned SETTLE0_P = SETTLE0_CYC,
  parameter int unsigned SETTLE1_P = SETTLE1_CYC,
  parameter int unsigned SETTLE2_P = SETTLE2_CYC,
  parameter int unsigned SETTLE3_P = SETTLE3_CYC
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire rcts_pkg::rcts_axi_req_s axi_req,
  output rcts_pkg::rcts_axi_rsp_s axi_rsp,
  input wire logic sense_ext,
  input wire logic sense_int,
  output logic cap_charge,
  output logic sense_port_a,
  output logic sense_port_b,
  output logic sense_port_c,
  output logic sense_port_d,
  output logic fast_osc_en,
  output logic irq,
  output logic irq_n
);
  import rcts_pkg::*;

  rcts_state_s s;
  rcts_state_s next_s;
  logic dummy7;
  logic cycle_long;
  logic four_ports;
  logic reverse;
  logic mains60;
  logic [1:0] factor;
  logic internal_trig;
  logic [2:0] osc_gating;
  logic timo_long;
  logic [3:0] n_dummy;
  logic [3:0] n_ports;
  logic [3:0] k;
  logic [1:0] cur_port;
  logic is_dummy;
  logic last_step;
  logic stop;
  logic timeout_hit;
  logic short_hit;
  logic open_hit;
  logic cmd_start;
  logic wr_fire;
  logic [CNT_W-1:0] cyc_len;
  logic [CNT_W-1:0] timo_len;

  assign dummy7 = s.ctrl[CB_DUMMY];
  assign cycle_long = s.ctrl[CB_CYCLE];
  assign four_ports = s.ctrl[CB_PORTS];
  assign reverse = s.ctrl[CB_ORDER];
  assign mains60 = s.ctrl[CB_MAINS];
  assign factor = s.ctrl[CB_FACTOR +: 2];
  assign internal_trig = s.ctrl[CB_TRIG];
  assign osc_gating = s.ctrl[CB_OSC +: 3];
  assign timo_long = s.ctrl[CB_TIMO];

  // RULE3: dummy discharge count
  assign n_dummy = dummy7 ? 4'h7 : 4'h2;
  // RULE5: enabled port count
  assign n_ports = four_ports ? 4'h4 : 4'h2;
  // RULE4: cycle length select
  assign cyc_len = cycle_long ? CNT_W'(CYC_LONG_P) : CNT_W'(CYC_SHORT);
  assign timo_len = timo_long ? CNT_W'(TIMO_LONG_P) : CNT_W'(TIMO_SHORT_P);

  assign is_dummy = s.step < n_dummy;
  assign k = s.step - n_dummy;
  // RULE6: port order and dummy port
  assign cur_port = is_dummy ? (reverse ? 2'h3 : 2'h0) : (reverse ? 2'h3 - k[1:0] : k[1:0]);
  assign last_step = s.step == n_dummy + n_ports - 4'h1;

  // RULE10: trigger path select
  // The external trigger inverts, so its end of discharge is a rising level.
  assign stop = internal_trig ? !s.sync_int[1] : s.sync_ext[1];
  assign timeout_hit = s.state == ST_DISCH && !stop && s.cnt == timo_len - CNT_W'(1);
  // RULE13: short-circuit detection
  assign short_hit = s.state == ST_DISCH && stop && s.cnt < CNT_W'(SHORT_CYC) && !is_dummy;
  // RULE14: open-circuit detection
  assign open_hit = timeout_hit && !is_dummy;

  assign wr_fire = !s.rsp.awready && !s.rsp.wready && !s.rsp.bvalid;
  assign cmd_start = wr_fire && s.waddr == OFF_CMD && s.state == ST_IDLE && s.wstrb[0]
    && (s.wdata[3:0] == OP_TEMP || s.wdata[3:0] == OP_TEMP_TWICE);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
    input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = nv[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb
  begin
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] wmerged;
    logic [ADDR_W-1:0] ra;
    logic [31:0] ctrl_m;
    ctrl_m = '0;
    set_bits = '0;
    clr_bits = '0;
    wmerged = '0;
    ra = axi_req.araddr;
    next_s = s;
    next_s.sync_ext = {s.sync_ext[0], sense_ext};
    next_s.sync_int = {s.sync_int[0], sense_int};

    // Write address and data are taken independently, in either order.
    if (s.rsp.awready && axi_req.awvalid)
    begin
      next_s.rsp.awready = 1'b0;
      next_s.waddr = axi_req.awaddr;
    end
    if (s.rsp.wready && axi_req.wvalid)
    begin
      next_s.rsp.wready = 1'b0;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (wr_fire)
    begin
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = RESP_OKAY;
      wmerged = merge(32'h0, s.wdata, s.wstrb);
      unique case (s.waddr)
        OFF_CTRL:
        begin
          // Configuration is frozen while a sequence runs so one run sees one setup.
          if (s.state == ST_IDLE)
          begin
            ctrl_m = merge({{(32 - CTRL_W){1'b0}}, s.ctrl}, s.wdata, s.wstrb);
            next_s.ctrl = ctrl_m[CTRL_W-1:0];
          end
        end
        OFF_CMD:
        begin
        end
        OFF_STATUS: clr_bits = wmerged;
        OFF_MASK: next_s.mask = merge(s.mask, s.wdata, s.wstrb);
        default: next_s.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (s.rsp.bvalid && axi_req.bready)
    begin
      next_s.rsp.bvalid = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end

    if (s.rsp.arready && axi_req.arvalid)
    begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = RESP_OKAY;
      unique case (ra)
        OFF_CTRL: next_s.rsp.rdata = {{(32 - CTRL_W){1'b0}}, s.ctrl};
        OFF_CMD: next_s.rsp.rdata = 32'h00000000;
        OFF_STATUS: next_s.rsp.rdata = s.status;
        OFF_MASK: next_s.rsp.rdata = s.mask;
        OFF_RES0, OFF_RES0 + 8'h04, OFF_RES0 + 8'h08, OFF_RES0 + 8'h0C:
          next_s.rsp.rdata = s.res[ra[3:2]];
        OFF_STATE: next_s.rsp.rdata = {24'h000000, s.step, 1'b0, s.state};
        default:
        begin
          next_s.rsp.rdata = 32'h00000000;
          next_s.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rsp.rvalid && axi_req.rready)
    begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    unique case (s.state)
      ST_IDLE:
      begin
        if (cmd_start)
        begin
          // RULE19: new opcode releases interrupt
          next_s.irq_n = 1'b1;
          // RULE7: remember second pass
          next_s.rep2 = s.wdata[3:0] == OP_TEMP_TWICE;
          next_s.step = 4'h0;
          next_s.cyc = '0;
          // RULE17: settling delay before measuring
          if (osc_gating > 3'h1)
          begin
            next_s.state = ST_SETTLE;
            unique case (osc_gating)
              3'h2: next_s.cnt = CNT_W'(SETTLE0_P);
              3'h3: next_s.cnt = CNT_W'(SETTLE1_P);
              3'h4: next_s.cnt = CNT_W'(SETTLE2_P);
              default: next_s.cnt = CNT_W'(SETTLE3_P);
            endcase
          end
          else
          begin
            next_s.state = ST_CHARGE;
            next_s.cnt = '0;
          end
        end
      end
      ST_SETTLE:
      begin
        next_s.cnt = s.cnt - CNT_W'(1);
        if (s.cnt <= CNT_W'(1))
        begin
          next_s.state = ST_CHARGE;
          next_s.cnt = '0;
          next_s.cyc = '0;
        end
      end
      ST_CHARGE:
      begin
        next_s.cnt = s.cnt + CNT_W'(1);
        next_s.cyc = s.cyc + CNT_W'(1);
        if (s.cnt == CNT_W'(CHARGE_CYC - 1))
        begin
          // RULE1: open the port's discharge path
          next_s.state = ST_DISCH;
          next_s.cnt = '0;
          next_s.port_en = 4'h1 << cur_port;
        end
      end
      ST_DISCH:
      begin
        next_s.cnt = s.cnt + CNT_W'(1);
        next_s.cyc = s.cyc + CNT_W'(1);
        if (stop || timeout_hit)
        begin
          next_s.state = ST_REST;
          next_s.port_en = 4'h0;
          if (!is_dummy)
          begin
            // RULE11: one result register per port
            if (short_hit)
            begin
              // RULE12: short flag and code
              next_s.res[cur_port] = RES_SHORT;
              set_bits[SB_SHORT] = 1'b1;
            end
            else if (open_hit)
            begin
              // RULE12: open flag and code
              next_s.res[cur_port] = RES_OPEN;
              set_bits[SB_OPEN] = 1'b1;
            end
            else
            begin
              // RULE1: discharge time as reading
              next_s.res[cur_port] = {{(32 - CNT_W){1'b0}}, s.cnt};
            end
          end
        end
      end
      ST_REST:
      begin
        next_s.cyc = s.cyc + CNT_W'(1);
        // RULE4: pad each measurement to the cycle time
        if (s.cyc >= cyc_len - CNT_W'(1))
        begin
          next_s.cyc = '0;
          next_s.cnt = '0;
          if (!last_step)
          begin
            next_s.step = s.step + 4'h1;
            next_s.state = ST_CHARGE;
          end
          else if (s.rep2)
          begin
            // RULE8: mains period select
            // RULE9: quarter periods times code plus two
            next_s.cnt = CNT_W'((mains60 ? QTR60_P : QTR50_P) * (32'(factor) + 32'd2));
            next_s.rep2 = 1'b0;
            next_s.step = 4'h0;
            next_s.state = ST_MAINS;
          end
          else
          begin
            // RULE2: completion only after the last port
            next_s.state = ST_IDLE;
            next_s.irq_n = 1'b0;
            set_bits[SB_DONE] = 1'b1;
          end
        end
      end
      ST_MAINS:
      begin
        next_s.cnt = s.cnt - CNT_W'(1);
        if (s.cnt <= CNT_W'(1))
        begin
          // RULE7: second full pass
          next_s.state = ST_CHARGE;
          next_s.cnt = '0;
          next_s.cyc = '0;
        end
      end
      default: next_s.state = ST_IDLE;
    endcase

    next_s.charge = next_s.state == ST_CHARGE;
    // RULE18: gated oscillator follows the run
    next_s.osc_en = osc_gating == 3'h1 || (osc_gating > 3'h1 && next_s.state != ST_IDLE);
    // Hardware set wins over a software clear in the same cycle.
    next_s.status = (s.status & ~clr_bits) | set_bits;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign cap_charge = s.charge;
  assign sense_port_a = s.port_en[0];
  assign sense_port_b = s.port_en[1];
  assign sense_port_c = s.port_en[2];
  assign sense_port_d = s.port_en[3];
  assign fast_osc_en = s.osc_en;
  assign irq = s.irq;
  assign irq_n = s.irq_n;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  short_zero_a: assert property (short_hit |=> s.res[$past(cur_port)] == RES_SHORT) // RULE13
    else $error("Short discharge did not store zero.");
  open_code_a: assert property (open_hit |=> s.res[$past(cur_port)] == RES_OPEN) // RULE14
    else $error("Timed out discharge did not store the open code.");
  flag_bits_a: assert property ((short_hit |=> s.status[SB_SHORT]) // RULE12
    and (open_hit |=> s.status[SB_OPEN]))
    else $error("Short or open flag not set.");
  done_last_a: assert property ($fell(s.irq_n) |-> $past(last_step) && s.state == ST_IDLE) // RULE2
    else $error("Completion flagged before the last port.");
  irq_hold_a: assert property (!s.irq_n && !cmd_start |=> !s.irq_n) // RULE19
    else $error("Interrupt released without a new opcode.");
  osc_start_a: assert property (cmd_start && osc_gating > 3'h1 // RULE18
    |=> s.osc_en && s.state == ST_SETTLE)
    else $error("Oscillator not started with settling delay.");
  osc_off_a: assert property (osc_gating == 3'h0 && s.state != ST_IDLE |-> !s.osc_en) // RULE17
    else $error("Oscillator on while its control is off.");
  dummy_port_a: assert property (s.state == ST_DISCH && is_dummy // RULE6
    |-> s.port_en == (reverse ? 4'h8 : 4'h1))
    else $error("Dummy discharge on the wrong port.");
  two_ports_a: assert property (s.state == ST_DISCH && !four_ports // RULE5
    |-> s.port_en == (reverse ? 4'h8 : 4'h1) || s.port_en == (reverse ? 4'h4 : 4'h2))
    else $error("Port outside the enabled set.");
  one_path_a: assert property (s.state == ST_DISCH |-> $onehot(s.port_en) && !s.charge) // RULE1
    else $error("Discharge path not exactly one port.");
  mains_quiet_a: assert property (s.state == ST_MAINS |-> s.irq_n && !s.rep2) // RULE7
    else $error("Completion raised before the second pass.");

  short_seen_c: cover property (short_hit);
  open_seen_c: cover property (open_hit);
  twice_c: cover property (s.state == ST_MAINS ##1 s.state == ST_CHARGE);
  rev_done_c: cover property (reverse && four_ports && $fell(s.irq_n));
endmodule : rcts_top
